// >>> tds_pkg.sv
// Package for the timer with delta-sigma audio output.
// Assumes a single 100 MHz clock and an 8-bit register port.
package tds_pkg;
	localparam logic [7:0] TDS_ADDR_TERM_LOW = 8'hDA;
	localparam logic [7:0] TDS_ADDR_TERM_HIGH = 8'hDB;
	localparam logic [7:0] TDS_ADDR_SAMPLE_LOW = 8'hDC;
	localparam logic [7:0] TDS_ADDR_SAMPLE_HIGH = 8'hDD;
	localparam logic [7:0] TDS_ADDR_COUNT_LOW = 8'hE2;
	localparam logic [7:0] TDS_ADDR_COUNT_HIGH = 8'hE3;
	localparam logic [7:0] TDS_ADDR_CTRL = 8'hE4;
	localparam logic [7:0] TDS_ADDR_CHAN0_CTRL = 8'hE5;
	localparam logic [7:0] TDS_ADDR_CHAN1_CTRL = 8'hE6;
	localparam logic [7:0] TDS_ADDR_IRQ_MASK = 8'hE7;
	localparam logic [7:0] TDS_CHAN_CTRL_RESET = 8'h40;
	localparam logic [2:0] TDS_CMP_DSM = 3'h7;
	localparam int TDS_FLAG_CH2 = 7;
	localparam int TDS_FLAG_CH1 = 6;
	localparam int TDS_FLAG_CH0 = 5;
	localparam int TDS_FLAG_OVF = 4;
	localparam logic [3:0] TDS_FLAG_CLEAR = 4'h0;
	localparam logic [15:0] TDS_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TDS_COUNT_ZERO = 16'h0000;
	localparam logic [6:0] TDS_DIV8 = 7'h07;
	localparam logic [6:0] TDS_DIV32 = 7'h1F;
	localparam logic [6:0] TDS_DIV128 = 7'h7F;
	localparam logic [2:0] TDS_DSM_DIV4 = 3'h3;
	localparam logic [2:0] TDS_DSM_DIV8 = 3'h7;
	localparam int TDS_SAMPLE_DROP = 2;

	typedef enum logic [1:0] {
		TDS_MODE_SUSPEND = 2'b00,
		TDS_MODE_FREE = 2'b01,
		TDS_MODE_MODULO = 2'b10,
		TDS_MODE_UPDOWN = 2'b11
	} tds_mode_t;

	typedef enum logic [1:0] {
		TDS_DIV_1 = 2'b00,
		TDS_DIV_8 = 2'b01,
		TDS_DIV_32 = 2'b10,
		TDS_DIV_128 = 2'b11
	} tds_div_t;

	typedef struct packed {
		logic [3:0] flags;
		tds_div_t div;
		tds_mode_t mode;
	} tds_ctrl_t;

	typedef struct packed {
		logic capture_select;
		logic irq_mask;
		logic [2:0] compare_action_select;
		logic mode;
		logic [1:0] capture_edge_select;
	} tds_chan_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tds_bus_t;
endpackage

// >>> tds_dsm.sv
// Second-order one-bit delta-sigma modulator with interpolator and shaper.
// Assumes samples and the sample strobe come from the timer on one clock.
`timescale 1ns/10ps
`default_nettype none
module tds_dsm #(
	parameter int SW = 16
) (
	input wire logic i_ref_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_enable, // modulator enabled
	input wire logic i_slow, // one eighth tick rate when high
	input wire logic i_hold, // zeroth order hold instead of interpolation
	input wire logic i_shape, // shaper on
	input wire logic i_tick, // timer tick enable
	input wire logic i_sample_stb, // new sample period begins
	input wire logic [SW-1:0] i_sample, // signed sample
	output logic o_bit // modulated output
);
	localparam int AW = SW + 8;
	logic [2:0] phase;
	logic signed [SW-1:0] cur, prev;
	logic signed [AW-1:0] interp, step, acc1, acc2;
	logic signed [SW-1:0] clean;
	logic signed [AW-1:0] fb;
	logic dsm_en, out_bit, decide;
	logic [2:0] top;
	logic [15:0] steps, steps_seen;

	assign top = i_slow ? tds_pkg::TDS_DSM_DIV8 : tds_pkg::TDS_DSM_DIV4;
	assign dsm_en = i_tick && (phase == top);
	// Two low bits are dropped so only 14 bits take part.
	assign clean = {i_sample[SW-1:tds_pkg::TDS_SAMPLE_DROP],
		{tds_pkg::TDS_SAMPLE_DROP{1'b0}}};
	// The decision comes from the present second integrator, not from the
	// registered bit: one more step of loop delay makes the loop diverge.
	assign decide = ~acc2[AW-1];
	assign fb = decide ? (AW)'(signed'({1'b0, {(SW-1){1'b1}}}))
		: -(AW)'(signed'({1'b0, {(SW-1){1'b1}}}));

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase <= '0;
		end else if (!i_enable) begin
			phase <= '0;
		end else if (i_tick) begin
			phase <= (phase == top) ? 3'h0 : phase + 3'h1;
		end
	end

	// The interpolation step is scaled by the steps counted in the period before the last
	// period; a single divide-free shift keeps area small at some gain error.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur <= '0;
			prev <= '0;
			interp <= '0;
			step <= '0;
			steps <= 16'h0001;
			steps_seen <= '0;
		end else if (i_sample_stb) begin
			prev <= cur;
			cur <= clean;
			steps <= (steps_seen == 16'h0000) ? 16'h0001 : steps_seen;
			steps_seen <= '0;
			interp <= (AW)'(cur);
			step <= ((AW)'(clean) - (AW)'(cur)) >>> $clog2(steps + 16'h0001);
		end else if (dsm_en) begin
			steps_seen <= steps_seen + 16'h0001;
			if (!i_hold) begin
				interp <= interp + step;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc1 <= '0;
			acc2 <= '0;
			out_bit <= 1'b0;
		end else if (!i_enable) begin
			acc1 <= '0;
			acc2 <= '0;
			out_bit <= 1'b0;
		end else if (dsm_en) begin
			acc1 <= acc1 + (i_hold ? (AW)'(cur) : interp) - fb;
			acc2 <= acc2 + acc1 - (fb <<< 1);
			out_bit <= decide;
		end
	end

	// The shaper forces an edge pair per bit to even out rise and fall times.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bit <= 1'b0;
		end else if (!i_enable) begin
			o_bit <= 1'b0;
		end else if (i_shape && phase == 3'h0) begin
			o_bit <= 1'b0;
		end else if (i_shape && phase == top) begin
			o_bit <= 1'b1;
		end else begin
			o_bit <= out_bit;
		end
	end
endmodule
`default_nettype wire

// >>> tds_timer.sv
// Top of the 16-bit timer with prescaler, event flags and audio modulator.
// Assumes a one-cycle tick enable and the plain register port.
`timescale 1ns/10ps
`default_nettype none
module tds_timer (
	input wire logic i_ref_clk, // 100 MHz clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_tick, // timer tick enable pulse
	input wire logic [7:0] i_addr, // register address
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [7:0] o_rdata, // read data, cycle after strobe
	output logic o_irq, // level interrupt
	output logic o_dsm_out, // channel 1 audio stream
	output logic o_dma_trig // one-cycle sample request
);
	tds_pkg::tds_ctrl_t ctrl;
	tds_pkg::tds_chan_t chan0, chan1;
	tds_pkg::tds_bus_t bus;
	logic [15:0] counter_value, term, sample;
	logic [7:0] term_low_buf, sample_low_buf, count_high_byte, irq_mask;
	logic [6:0] presc;
	logic count_down, active_edge, dsm_on, dsm_bit;
	logic ovf_ev, ch0_ev, ch1_ev, ch2_ev;
	logic [3:0] flag_set, flag_clr, flags_next;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign dsm_on = chan1.compare_action_select == tds_pkg::TDS_CMP_DSM;

	// The prescaler counter runs freely so a divider change applies at once
	// to the running count, without waiting for the current period.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc <= '0;
		end else if (i_tick) begin
			presc <= presc + 7'h01;
		end
	end

	always_comb begin
		active_edge = 1'b0;
		if (i_tick) begin
			case (ctrl.div)
				tds_pkg::TDS_DIV_1: active_edge = 1'b1;
				tds_pkg::TDS_DIV_8:
					active_edge = (presc & tds_pkg::TDS_DIV8) == tds_pkg::TDS_DIV8;
				tds_pkg::TDS_DIV_32:
					active_edge = (presc & tds_pkg::TDS_DIV32) == tds_pkg::TDS_DIV32;
				tds_pkg::TDS_DIV_128: active_edge = presc == tds_pkg::TDS_DIV128;
				default: active_edge = 1'b0;
			endcase
			// The modulator cannot use the prescaler.
			if (dsm_on) begin
				active_edge = 1'b1;
			end
		end
	end

	always_comb begin
		ovf_ev = 1'b0;
		ch0_ev = 1'b0;
		if (active_edge) begin
			case (ctrl.mode)
				tds_pkg::TDS_MODE_FREE: ovf_ev = counter_value == tds_pkg::TDS_COUNT_MAX;
				tds_pkg::TDS_MODE_MODULO: ovf_ev = counter_value == term;
				tds_pkg::TDS_MODE_UPDOWN: ovf_ev = count_down &&
					counter_value == tds_pkg::TDS_COUNT_ZERO;
				default: ovf_ev = 1'b0;
			endcase
			if (ctrl.mode == tds_pkg::TDS_MODE_UPDOWN) begin
				ch0_ev = chan0.mode && ovf_ev;
			end else if (ctrl.mode != tds_pkg::TDS_MODE_SUSPEND) begin
				ch0_ev = chan0.mode && counter_value == term;
			end
		end
	end
	assign ch1_ev = active_edge && ctrl.mode != tds_pkg::TDS_MODE_SUSPEND &&
		chan1.mode && !dsm_on && counter_value == sample;
	assign ch2_ev = 1'b0;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			counter_value <= tds_pkg::TDS_COUNT_ZERO;
			count_down <= 1'b0;
		end else if (bus.wr && hit(bus.addr, tds_pkg::TDS_ADDR_COUNT_LOW)) begin
			counter_value <= tds_pkg::TDS_COUNT_ZERO;
			count_down <= 1'b0;
		end else if (active_edge) begin
			case (ctrl.mode)
				tds_pkg::TDS_MODE_FREE: counter_value <= counter_value + 16'h0001;
				tds_pkg::TDS_MODE_MODULO: counter_value <= (counter_value >= term) ?
					tds_pkg::TDS_COUNT_ZERO : counter_value + 16'h0001;
				tds_pkg::TDS_MODE_UPDOWN: begin
					if (!count_down && counter_value >= term) begin
						count_down <= term != tds_pkg::TDS_COUNT_ZERO;
						counter_value <= counter_value - 16'h0001;
					end else if (count_down &&
						counter_value == tds_pkg::TDS_COUNT_ZERO) begin
						count_down <= 1'b0;
						counter_value <= counter_value + 16'h0001;
					end else if (count_down) begin
						counter_value <= counter_value - 16'h0001;
					end else begin
						counter_value <= counter_value + 16'h0001;
					end
				end
				default: counter_value <= counter_value;
			endcase
		end
	end

	// Mode and divider take effect on the write itself, so a nonzero mode
	// starts counting on the next active prescaler edge. Writing one clears a flag, and a
	// new event in that cycle wins.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl.flags <= tds_pkg::TDS_FLAG_CLEAR;
			ctrl.mode <= tds_pkg::TDS_MODE_SUSPEND;
			ctrl.div <= tds_pkg::TDS_DIV_1;
		end else begin
			ctrl.flags <= flags_next;
			if (bus.wr && hit(bus.addr, tds_pkg::TDS_ADDR_CTRL)) begin
				ctrl.mode <= tds_pkg::tds_mode_t'(bus.wdata[1:0]);
				ctrl.div <= tds_pkg::tds_div_t'(bus.wdata[3:2]);
			end
		end
	end

	always_comb begin
		flag_set = '0;
		flag_set[tds_pkg::TDS_FLAG_CH2 - tds_pkg::TDS_FLAG_OVF] = ch2_ev;
		flag_set[tds_pkg::TDS_FLAG_CH1 - tds_pkg::TDS_FLAG_OVF] = ch1_ev;
		flag_set[tds_pkg::TDS_FLAG_CH0 - tds_pkg::TDS_FLAG_OVF] = ch0_ev;
		flag_set[0] = ovf_ev;
		flag_clr = '0;
		if (bus.wr && hit(bus.addr, tds_pkg::TDS_ADDR_CTRL)) begin
			flag_clr = bus.wdata[7:4];
		end
		flags_next = (ctrl.flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chan0 <= tds_pkg::TDS_CHAN_CTRL_RESET;
			chan1 <= tds_pkg::TDS_CHAN_CTRL_RESET;
			irq_mask <= '0;
		end else if (bus.wr) begin
			if (hit(bus.addr, tds_pkg::TDS_ADDR_CHAN0_CTRL)) begin
				chan0 <= bus.wdata;
			end
			if (hit(bus.addr, tds_pkg::TDS_ADDR_CHAN1_CTRL)) begin
				chan1 <= bus.wdata;
			end
			if (hit(bus.addr, tds_pkg::TDS_ADDR_IRQ_MASK)) begin
				irq_mask <= bus.wdata;
			end
		end
	end

	// Low bytes wait in a buffer so a 16-bit value never tears.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			term <= '0;
			sample <= '0;
			term_low_buf <= '0;
			sample_low_buf <= '0;
		end else if (bus.wr) begin
			if (hit(bus.addr, tds_pkg::TDS_ADDR_TERM_LOW)) begin
				term_low_buf <= bus.wdata;
			end
			if (hit(bus.addr, tds_pkg::TDS_ADDR_TERM_HIGH)) begin
				term <= {bus.wdata, term_low_buf};
			end
			if (hit(bus.addr, tds_pkg::TDS_ADDR_SAMPLE_LOW)) begin
				sample_low_buf <= bus.wdata;
			end
			if (hit(bus.addr, tds_pkg::TDS_ADDR_SAMPLE_HIGH)) begin
				sample <= {bus.wdata, sample_low_buf};
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_high_byte <= '0;
		end else if (bus.rd && hit(bus.addr, tds_pkg::TDS_ADDR_COUNT_LOW)) begin
			count_high_byte <= counter_value[15:8];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (bus.rd) begin
			case (bus.addr)
				tds_pkg::TDS_ADDR_TERM_LOW: o_rdata <= term[7:0];
				tds_pkg::TDS_ADDR_TERM_HIGH: o_rdata <= term[15:8];
				tds_pkg::TDS_ADDR_SAMPLE_LOW: o_rdata <= sample[7:0];
				tds_pkg::TDS_ADDR_SAMPLE_HIGH: o_rdata <= sample[15:8];
				tds_pkg::TDS_ADDR_COUNT_LOW: o_rdata <= counter_value[7:0];
				tds_pkg::TDS_ADDR_COUNT_HIGH: o_rdata <= count_high_byte;
				tds_pkg::TDS_ADDR_CTRL: o_rdata <= ctrl;
				tds_pkg::TDS_ADDR_CHAN0_CTRL: o_rdata <= chan0;
				tds_pkg::TDS_ADDR_CHAN1_CTRL: o_rdata <= chan1;
				tds_pkg::TDS_ADDR_IRQ_MASK: o_rdata <= irq_mask;
				default: o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// Each channel 0 event (ch0_ev) asks software for the next sample.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
			o_dma_trig <= 1'b0;
		end else begin
			o_irq <= |(flags_next & irq_mask[7:4]);
			o_dma_trig <= ch0_ev;
		end
	end

	tds_dsm #(
		.SW(16)
	) u_dsm (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_enable(dsm_on),
		.i_slow(chan1.mode),
		.i_hold(chan1.capture_edge_select[1]),
		.i_shape(chan1.capture_edge_select[0]),
		.i_tick(i_tick),
		.i_sample_stb(ovf_ev),
		.i_sample(sample),
		.o_bit(dsm_bit)
	);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dsm_out <= 1'b0;
		end else begin
			o_dsm_out <= dsm_bit;
		end
	end
endmodule
`default_nettype wire

// >>> tds_timer_assertions.sv
// Checker for the timer top: bus answers, interrupt and audio stream.
// Assumes the plain register port and a single clock domain.
`timescale 1ns/10ps
`default_nettype none
module tds_timer_assertions (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_tick, // tick enable
	input wire logic [7:0] i_addr, // address
	input wire logic [7:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	input wire logic [7:0] o_rdata, // read data
	input wire logic o_irq, // interrupt
	input wire logic o_dsm_out, // audio stream
	input wire logic o_dma_trig // sample request
);
	localparam logic [7:0] CL = tds_pkg::TDS_ADDR_COUNT_LOW;
	localparam logic [7:0] CH1 = tds_pkg::TDS_ADDR_CHAN1_CTRL;
	localparam logic [7:0] MSK = tds_pkg::TDS_ADDR_IRQ_MASK;
	logic [1:0] mode_q;
	logic [3:0] off_cnt;
	wire logic cl_rd = i_rd && i_addr == CL;
	wire logic dsm_wr = i_wr && i_addr == CH1 &&
		i_wdata[5:3] == tds_pkg::TDS_CMP_DSM;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			mode_q <= 2'h0;
		else if (i_wr && i_addr == tds_pkg::TDS_ADDR_CTRL)
			mode_q <= i_wdata[1:0];
	end

	// The modulator may drain its pipeline for a while after it is switched off.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			off_cnt <= 4'hf;
		else if (i_wr && i_addr == CH1)
			off_cnt <= dsm_wr ? 4'h0 : 4'h1;
		else if (off_cnt != 4'h0 && off_cnt != 4'hf)
			off_cnt <= off_cnt + 4'h1;
	end

	chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	chk_unmapped_read: assert property (i_rd && i_addr == 8'h00 |=>
		o_rdata == 8'h00) else $error("unmapped read not zero");
	chk_count_clear: assert property (mode_q == 2'h0 && i_wr &&
		i_addr == CL ##2 cl_rd |=> o_rdata == 8'h00)
		else $error("count not cleared by low byte write");
	chk_suspend_frozen: assert property (mode_q == 2'h0 && cl_rd
		##1 !i_wr ##1 mode_q == 2'h0 && cl_rd |=>
		o_rdata == $past(o_rdata, 2)) else $error("count moved while suspended");
	chk_irq_masked: assert property (i_wr && i_addr == MSK &&
		i_wdata[7:4] == 4'h0 ##1 !(i_wr && i_addr == MSK) |=> !o_irq)
		else $error("interrupt high with all masks clear");
	chk_dma_pulse: assert property (o_dma_trig |=> !o_dma_trig)
		else $error("sample request longer than one cycle");
	chk_dsm_off: assert property (off_cnt == 4'hf |-> !o_dsm_out)
		else $error("stream active with modulator off");
	chk_dsm_start: assert property (dsm_wr |-> ##[1:200] o_dsm_out)
		else $error("modulator did not start");

	cover property (o_irq);
	cover property (o_dma_trig);
	cover property ($rose(o_dsm_out));
endmodule

bind tds_timer tds_timer_assertions chk_u (.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n), .i_tick(i_tick), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_irq(o_irq), .o_dsm_out(o_dsm_out), .o_dma_trig(o_dma_trig));
`default_nettype wire

// >>> tds_timer_tb.sv
// Self-checking bench for the timer with audio modulator.
// Assumes the checker is bound to the timer top; tick held high.
`timescale 1ns/10ps
`default_nettype none
module tds_timer_tb;
	logic clk, rst_n, tick, wr, rd, irq, dsm, trig;
	logic [7:0] addr, wdata, rdata, d;
	logic [15:0] v0, v1;
	int error_cnt, tests_run, n, k;
	int dv[4] = '{1, 8, 32, 128};
	logic [7:0] ra[8] = '{8'he2, 8'he2, 8'he3, 8'he4, 8'he5, 8'he6, 8'he7, 8'h00};
	logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00, 8'h00};

	tds_timer dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_tick(tick),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_irq(irq), .o_dsm_out(dsm), .o_dma_trig(trig));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic test_done();
		$display("errors=%0d checks=%0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// An unknown count makes the range test unknown, which is a mismatch.
	task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
		tests_run++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic bw(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic br(input logic [7:0] a, output logic [7:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk);
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	// In modulator mode every sample request is answered by reloading the
	// sample, low byte first, as the host side is expected to do.
	task automatic run(input int m, input bit sel, input logic [15:0] s,
		output int c);
		bit hi;
		c = 0;
		hi = 1'b0;
		repeat (m) begin
			@(posedge clk);
			c += sel ? int'(dsm) : int'(trig);
			if (sel) begin
				wr <= trig || hi;
				addr <= hi ? 8'hdd : 8'hdc;
				wdata <= hi ? s[15:8] : s[7:0];
				hi = trig;
			end
		end
		if (sel) begin
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask

	task automatic dsm_run(input logic [15:0] s, output int c);
		do_reset();
		bw(8'he4, 8'h00);
		bw(8'he2, 8'h00);
		bw(8'hda, 8'h3f);
		bw(8'hdb, 8'h00);
		bw(8'he5, 8'h44);
		bw(8'hdc, s[7:0]);
		bw(8'hdd, s[15:8]);
		bw(8'he4, 8'h02);
		bw(8'he6, 8'h02);
		bw(8'he6, 8'h3a);
		run(2000, 1'b1, s, c);
	endtask

	initial begin
		{wr, rd, addr, wdata} = '0;
		tick = 1'b1;
		rst_n = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		void'($urandom(32'hed84));
		do_reset();
		foreach (ra[i]) begin
			br(ra[i], d);
			chk8(d, rv[i]);
		end
		bw(8'he2, 8'($urandom));
		br(8'he2, d);
		chk8(d, 8'h00);
		// The high byte write must be ignored, so the count is exact undivided and within one when divided.
		for (int i = 0; i < 4; i++) begin
			k = 200 + $urandom_range(800);
			bw(8'he4, {4'h0, 2'(i), 2'h0});
			bw(8'he2, 8'($urandom));
			bw(8'he3, 8'($urandom));
			bw(8'he4, {4'h0, 2'(i), 2'h1});
			repeat (k) @(posedge clk);
			bw(8'he4, {4'h0, 2'(i), 2'h0});
			br(8'he2, v0[7:0]);
			br(8'he3, v0[15:8]);
			n = (k + 2) / dv[i];
			chk_rng(v0, n - (i > 0), n + (i > 0));
		end
		bw(8'he4, 8'h01);
		repeat ($urandom_range(300)) @(posedge clk);
		bw(8'he2, 8'($urandom));
		br(8'he2, d);
		chk8(d, 8'h01);
		br(8'he2, v0[7:0]);
		repeat (296) @(posedge clk);
		br(8'he3, v0[15:8]);
		br(8'he2, v1[7:0]);
		br(8'he3, v1[15:8]);
		chk_rng(v1 - v0, 300, 300);
		bw(8'he4, 8'h00);
		bw(8'he2, 8'h00);
		bw(8'he5, 8'h44);
		bw(8'hda, 8'h1f);
		bw(8'hdb, 8'h00);
		bw(8'hda, 8'h03);
		bw(8'he4, 8'h02);
		run(320, 1'b0, 16'h0000, n);
		chk_rng(16'(n), 9, 11);
		bw(8'he4, 8'h00);
		bw(8'he2, 8'h00);
		bw(8'hdb, 8'h00);
		bw(8'he4, 8'h02);
		run(320, 1'b0, 16'h0000, n);
		chk_rng(16'(n), 79, 81);
		bw(8'he4, 8'h03);
		run(324, 1'b0, 16'h0000, n);
		chk_rng(16'(n), 53, 55);
		bw(8'he4, 8'h00);
		br(8'he4, d);
		chk8(d, 8'h30);
		bw(8'he7, 8'h00);
		@(posedge clk);
		chk8(8'(irq), 8'h00);
		bw(8'he7, 8'h10);
		@(posedge clk);
		chk8(8'(irq), 8'h01);
		bw(8'he4, 8'h10);
		br(8'he4, d);
		chk8(d, 8'h20);
		chk8(8'(irq), 8'h00);
		dsm_run(16'h6000, n);
		dsm_run(16'h6000 | 16'($urandom_range(3)), k);
		chk_rng(16'(k), n, n);
		chk_rng(16'(n), 1200, 2000);
		dsm_run(16'ha000, n);
		chk_rng(16'(n), 0, 800);
		test_done();
	end

	initial begin
		#500_000;
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
